// [src/charger_option_control.sv]
`timescale 1ns/1ps
module charger_option_control #(
    parameter logic [31:0] DEGLITCH_SHORT_CYC = charger_option_pkg::DEGLITCH_SHORT_CYC,
    parameter logic [31:0] DEGLITCH_LONG_CYC  = charger_option_pkg::DEGLITCH_LONG_CYC,
    parameter logic [35:0] WD_44_CYC          = charger_option_pkg::WD_44_CYC,
    parameter logic [35:0] WD_88_CYC          = charger_option_pkg::WD_88_CYC,
    parameter logic [35:0] WD_175_CYC         = charger_option_pkg::WD_175_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Decoded SMBus word transfers
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             cmd_ack,
    output logic [15:0]      cmd_rdata,
    // Analog comparator levels
    input  wire logic        supply_above_uvlo,
    input  wire logic        adapter_detect_above_0v6,
    input  wire logic        adapter_detect_above_2v4,
    input  wire logic        adapter_good_raw,
    input  wire logic        battery_below_fall,
    input  wire logic        battery_above_rise,
    // Power path
    output logic             adapter_good,
    output logic             adapter_switch,
    output logic             battery_switch,
    // Charge state
    output logic             charge_suspended,
    output logic             charge_inhibit,
    output logic             calibration_active,
    output logic             battery_depleted,
    // Option controls to the analog side
    output logic [1:0]       depletion_threshold_sel,
    output logic             freq_trim_enable,
    output logic             freq_trim_raise,
    output logic             high_side_short_threshold,
    output logic             low_side_short_threshold,
    output logic             current_monitor_output,
    output logic             input_overcurrent_limit
);

    // ==========================================================
    // Bus decode
    logic        bus_enabled;
    logic        wr_option;
    logic        rd_option;
    logic        wr_charge;
    logic        wr_voltage;

    assign bus_enabled = supply_above_uvlo && adapter_detect_above_0v6;
    assign wr_option   = cmd_valid && bus_enabled && cmd_write
                         && cmd_code == charger_option_pkg::CMD_OPTION;
    assign rd_option   = cmd_valid && bus_enabled && !cmd_write
                         && cmd_code == charger_option_pkg::CMD_OPTION;
    assign wr_voltage  = cmd_valid && bus_enabled && cmd_write
                         && cmd_code == charger_option_pkg::CMD_CHG_VOLTAGE;
    assign wr_charge   = wr_voltage || (cmd_valid && bus_enabled && cmd_write
                         && cmd_code == charger_option_pkg::CMD_CHG_CURRENT);
    assign cmd_ack     = rd_option || wr_option || wr_charge;

    // ==========================================================
    // Option word, charge voltage tracking, read data
    logic [15:0] option_q;
    logic [15:0] option_d;
    logic        volt_zero_q;
    logic        volt_zero_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        calib_done;
    logic [15:0] option_view;

    always_comb begin
        option_view = option_q;
        option_view[charger_option_pkg::BIT_PRESENT] = adapter_detect_above_2v4;
        option_d    = option_q;
        if (wr_option) begin
            option_d = cmd_wdata;
        end else if (calib_done) begin
            option_d[charger_option_pkg::BIT_CALIB] = 1'b0;
        end
        option_d[charger_option_pkg::BIT_PRESENT] = 1'b0;
        volt_zero_d = wr_voltage ? (cmd_wdata == 16'h0000) : volt_zero_q;
        rdata_d     = rd_option ? option_view : rdata_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            option_q    <= charger_option_pkg::OPTION_RESET;
            volt_zero_q <= 1'b1;
            rdata_q     <= 16'h0000;
        end else begin
            option_q    <= option_d;
            volt_zero_q <= volt_zero_d;
            rdata_q     <= rdata_d;
        end
    end

    assign cmd_rdata = rdata_q;

    // ==========================================================
    // Adapter-good deglitch with first-insertion override
    logic switch_was_off_q;
    logic switch_was_off_d;
    logic adapter_switch_q;
    logic adapter_switch_d;
    logic long_sel;

    assign long_sel = option_q[charger_option_pkg::BIT_DEGLITCH]
                      && switch_was_off_q;

    adapter_deglitch u_deglitch (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .raw_good  (adapter_good_raw),
        .long_sel  (long_sel),
        .short_cyc (DEGLITCH_SHORT_CYC),
        .long_cyc  (DEGLITCH_LONG_CYC),
        .good      (adapter_good)
    );

    // ==========================================================
    // Depletion comparator and calibration cycle
    logic depleted_q;
    logic depleted_d;
    logic discharging;

    always_comb begin
        depleted_d = depleted_q;
        if (volt_zero_q) begin
            depleted_d = 1'b0;
        end else if (battery_below_fall) begin
            depleted_d = 1'b1;
        end else if (battery_above_rise) begin
            depleted_d = 1'b0;
        end
    end

    assign discharging = option_q[charger_option_pkg::BIT_CALIB] && adapter_good;
    assign calib_done  = discharging && depleted_q;

    always_comb begin
        adapter_switch_d = adapter_good && !discharging;
        switch_was_off_d = switch_was_off_q || (adapter_switch_q && !adapter_switch_d);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            depleted_q       <= 1'b0;
            adapter_switch_q <= 1'b0;
            switch_was_off_q <= 1'b0;
        end else begin
            depleted_q       <= depleted_d;
            adapter_switch_q <= adapter_switch_d;
            switch_was_off_q <= switch_was_off_d;
        end
    end

    assign adapter_switch     = adapter_switch_q;
    assign battery_switch     = !adapter_switch_q;
    assign calibration_active = option_q[charger_option_pkg::BIT_CALIB];
    assign battery_depleted   = depleted_q;

    // ==========================================================
    // Charge watchdog
    logic [35:0] wd_count_q;
    logic [35:0] wd_count_d;
    logic        suspended_q;
    logic        suspended_d;
    logic [35:0] wd_limit;
    logic [1:0]  wd_mode;
    logic        wd_expire;

    assign wd_mode = option_q[charger_option_pkg::BIT_WD_HI:charger_option_pkg::BIT_WD_LO];

    always_comb begin
        unique case (wd_mode)
            charger_option_pkg::WD_44: wd_limit = WD_44_CYC;
            charger_option_pkg::WD_88: wd_limit = WD_88_CYC;
            default:                   wd_limit = WD_175_CYC;
        endcase
        wd_expire  = wd_mode != charger_option_pkg::WD_OFF && !suspended_q
                     && wd_count_q >= wd_limit - 36'h1;
        wd_count_d = wd_count_q;
        if (wr_charge || wd_mode == charger_option_pkg::WD_OFF || suspended_q) begin
            wd_count_d = 36'h0;
        end else begin
            wd_count_d = wd_count_q + 36'h1;
        end
        suspended_d = suspended_q;
        if (wd_expire) begin
            suspended_d = 1'b1;
        end else if (wr_charge || wd_mode == charger_option_pkg::WD_OFF) begin
            suspended_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wd_count_q  <= 36'h0;
            suspended_q <= 1'b0;
        end else begin
            wd_count_q  <= wd_count_d;
            suspended_q <= suspended_d;
        end
    end

    assign charge_suspended = suspended_q;

    // ==========================================================
    // Option controls
    assign charge_inhibit            = option_q[charger_option_pkg::BIT_INHIBIT];
    assign depletion_threshold_sel   =
        option_q[charger_option_pkg::BIT_DEPL_HI:charger_option_pkg::BIT_DEPL_LO];
    assign freq_trim_enable          = option_q[charger_option_pkg::BIT_FREQ_EN];
    assign freq_trim_raise           = option_q[charger_option_pkg::BIT_FREQ_UP];
    assign high_side_short_threshold = option_q[charger_option_pkg::BIT_HS_SHORT];
    assign low_side_short_threshold  = option_q[charger_option_pkg::BIT_LS_SHORT];
    assign current_monitor_output    = option_q[charger_option_pkg::BIT_MON_SEL];
    assign input_overcurrent_limit   = option_q[charger_option_pkg::BIT_IN_OC];

endmodule // charger_option_control

// [src/charger_option_pkg.sv]
// What this block does
// - Word write to command 0x12 stores options
// - First adapter insertion always uses 150ms deglitch
// - Deglitch select applies after adapter switch off
// - Deglitch bit: 0 150ms, 1 1.3s, POR 1
// - Bus answers only above UVLO and 0.6V
// - Missing charge setting write suspends charging
// - Charge setting write resumes suspended charging
// - Depletion in calibration: battery off, adapter on
// - Depletion comparator releases 340mV above fall
// - Zero charge voltage disables depletion detection
// - Depletion threshold field selects four percentages
// - Frequency direction bit lowers or raises 18%
// - Frequency trim applies only when enabled
// - High-side short: off or 750mV, POR 1
// - Low-side short: 135mV or 230mV, POR 0
// - Presence bit follows 2.4V detect, read-only
// - Calibration bit starts discharge, self-clears
// - Input overcurrent off or 3.33x limit
package charger_option_pkg;

    // ==========================================================
    // Commands
    localparam logic [7:0]  CMD_OPTION       = 8'h12;
    localparam logic [7:0]  CMD_CHG_CURRENT  = 8'h14;
    localparam logic [7:0]  CMD_CHG_VOLTAGE  = 8'h15;

    // ==========================================================
    // Option word layout and reset value
    localparam logic [15:0] OPTION_RESET     = 16'hF902;
    localparam int          BIT_DEGLITCH     = 15;
    localparam int          BIT_WD_HI        = 14;
    localparam int          BIT_WD_LO        = 13;
    localparam int          BIT_DEPL_HI      = 12;
    localparam int          BIT_DEPL_LO      = 11;
    localparam int          BIT_FREQ_UP      = 10;
    localparam int          BIT_FREQ_EN      = 9;
    localparam int          BIT_HS_SHORT     = 8;
    localparam int          BIT_LS_SHORT     = 7;
    localparam int          BIT_CALIB        = 6;
    localparam int          BIT_MON_SEL      = 5;
    localparam int          BIT_PRESENT      = 4;
    localparam int          BIT_IN_OC        = 1;
    localparam int          BIT_INHIBIT      = 0;

    localparam logic [1:0]  WD_OFF           = 2'h0;
    localparam logic [1:0]  WD_44            = 2'h1;
    localparam logic [1:0]  WD_88            = 2'h2;

    // ==========================================================
    // Timing
    localparam longint unsigned CLK_HZ          = 200_000_000;
    localparam longint unsigned DEGLITCH_SHORT_MS = 150;
    localparam longint unsigned DEGLITCH_LONG_MS  = 1300;
    localparam longint unsigned WD_44_S         = 44;
    localparam longint unsigned WD_88_S         = 88;
    localparam longint unsigned WD_175_S        = 175;

    localparam logic [31:0] DEGLITCH_SHORT_CYC = 32'(DEGLITCH_SHORT_MS * CLK_HZ / 1000);
    localparam logic [31:0] DEGLITCH_LONG_CYC  = 32'(DEGLITCH_LONG_MS * CLK_HZ / 1000);
    localparam logic [35:0] WD_44_CYC          = 36'(WD_44_S * CLK_HZ);
    localparam logic [35:0] WD_88_CYC          = 36'(WD_88_S * CLK_HZ);
    localparam logic [35:0] WD_175_CYC         = 36'(WD_175_S * CLK_HZ);

endpackage

// [src/adapter_deglitch.sv]
`timescale 1ns/1ps
module adapter_deglitch (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Detector
    input  wire logic        raw_good,
    input  wire logic        long_sel,
    input  wire logic [31:0] short_cyc,
    input  wire logic [31:0] long_cyc,
    // Result
    output logic             good
);

    logic [31:0] count_q;
    logic [31:0] count_d;
    logic        good_q;
    logic        good_d;
    logic [31:0] target;

    // ==========================================================
    // Rising edge filtered, falling edge immediate
    always_comb begin
        target  = long_sel ? long_cyc : short_cyc;
        count_d = count_q;
        good_d  = good_q;
        if (!raw_good) begin
            count_d = 32'h0;
            good_d  = 1'b0;
        end else if (!good_q) begin
            if (count_q >= target - 32'h1) begin
                good_d = 1'b1;
            end else begin
                count_d = count_q + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= 32'h0;
            good_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            good_q  <= good_d;
        end
    end

    assign good = good_q;

endmodule // adapter_deglitch

// [bench/charger_option_properties.sv]
`timescale 1ns/1ps
module charger_option_properties (
    // Clock, reset, bus
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic        cmd_ack,
    input wire logic [15:0] cmd_rdata,
    // Levels and outputs
    input wire logic        supply_above_uvlo,
    input wire logic        adapter_detect_above_0v6,
    input wire logic        adapter_detect_above_2v4,
    input wire logic        adapter_good_raw,
    input wire logic        adapter_good,
    input wire logic        adapter_switch,
    input wire logic        battery_switch,
    input wire logic        calibration_active,
    input wire logic        battery_depleted,
    input wire logic        charge_suspended,
    input wire logic [1:0]  depletion_threshold_sel,
    input wire logic        freq_trim_raise,
    input wire logic        freq_trim_enable
);
    // ==========================================================
    // Bus acceptance
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire bus_on = supply_above_uvlo && adapter_detect_above_0v6;
    wire opt_wr = cmd_valid && cmd_write && cmd_code == 8'h12 && bus_on;
    opt_ack_a: assert property (opt_wr |-> cmd_ack) else $error("option write not acked");
    bus_off_a: assert property (cmd_valid && !bus_on |-> !cmd_ack)
        else $error("ack bus off");
    unmapped_a: assert property (cmd_valid && !(cmd_code inside {8'h12, 8'h14, 8'h15})
        |-> !cmd_ack) else $error("unmapped code acked");
    opt_store_a: assert property (opt_wr |=>
        depletion_threshold_sel == $past(cmd_wdata[12:11])
        && freq_trim_raise == $past(cmd_wdata[10]) && freq_trim_enable == $past(cmd_wdata[9]))
        else $error("option fields not stored");
    present_rd_a: assert property (cmd_valid && cmd_ack && !cmd_write |=>
        cmd_rdata[4] == $past(adapter_detect_above_2v4)) else $error("presence bit wrong");
    // ==========================================================
    // Power path
    switch_pair_a: assert property (battery_switch == !adapter_switch
        && (!adapter_switch || $past(adapter_good))) else $error("switch pair wrong");
    calib_off_a: assert property (calibration_active && adapter_good |=> !adapter_switch)
        else $error("adapter switch on in calibration");
    depl_end_a: assert property (calibration_active && battery_depleted && adapter_good
        && !(cmd_valid && cmd_write) |=> !calibration_active) else $error("calibration kept");
    good_fall_a: assert property (!adapter_good_raw |=> !adapter_good)
        else $error("good held");
    susp_clear_a: assert property (charge_suspended && cmd_valid && cmd_write && bus_on
        && cmd_code inside {8'h14, 8'h15} |=> !charge_suspended) else $error("suspension kept");
    cover property (opt_wr);
    cover property ($fell(calibration_active));
    cover property ($rose(adapter_good));
endmodule // charger_option_properties

// [bench/smbus_host_model.sv]
`timescale 1ns/1ps
module smbus_host_model (
    // Clock
    input wire logic    sys_clk,
    // Word transfers
    output logic        cmd_valid,
    output logic        cmd_write,
    output logic [7:0]  cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic    cmd_ack
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // One word transfer, held over one rising edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic a);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge sys_clk);
        a = cmd_ack;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        // Released code and data lines never keep the last value; cmd_write keeps it
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
endmodule // smbus_host_model

// [bench/charger_option_control_bench.sv]
`timescale 1ns/1ps
module charger_option_control_bench;
    logic sys_clk = 1'b0, rst = 1'b1, cmd_valid, cmd_write, cmd_ack;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, w, e;
    logic supply_above_uvlo = 1'b1, adapter_detect_above_0v6 = 1'b1;
    logic adapter_detect_above_2v4 = 1'b0;
    logic adapter_good_raw = 1'b0, battery_below_fall = 1'b0, battery_above_rise = 1'b0;
    logic adapter_good, adapter_switch, battery_switch, charge_suspended, charge_inhibit;
    logic calibration_active, battery_depleted, freq_trim_enable, freq_trim_raise;
    logic high_side_short_threshold, low_side_short_threshold, current_monitor_output;
    logic input_overcurrent_limit;
    logic [1:0] depletion_threshold_sel;
    wire [8:0] opts = {depletion_threshold_sel, freq_trim_raise, freq_trim_enable,
        high_side_short_threshold, low_side_short_threshold, current_monitor_output,
        input_overcurrent_limit, charge_inhibit};
    logic [15:0] exp_q[$];
    int n_fail = 0, cmp_count = 0, lim[3] = '{30, 60, 100};
    always #2.5 sys_clk = ~sys_clk;
    charger_option_control #(.DEGLITCH_SHORT_CYC(32'h8), .DEGLITCH_LONG_CYC(32'h14),
        .WD_44_CYC(36'h1E), .WD_88_CYC(36'h3C), .WD_175_CYC(36'h64)) i_dut (.*);
    smbus_host_model i_host (.*);
    // ==========================================================
    // Helpers
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
        cmp_count++;
        if (s !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Reads expected to be acked note their expected word in the queue
    task automatic op(input logic wr, input logic [7:0] c, input logic [15:0] d, input logic ea);
        logic a;
        if (!wr && ea) exp_q.push_back(d);
        i_host.xfer(wr, c, d, a);
        chk("cmd_ack", 16'(ea), 16'(a));
    endtask
    task automatic deg(input int n);
        adapter_good_raw = 1'b1;
        cyc(n - 2);
        chk("adapter_good early", 16'h0, 16'(adapter_good));
        cyc(5);
        chk("adapter_good", 16'h1, 16'(adapter_good));
        adapter_good_raw = 1'b0;
        cyc(2);
    endtask
    task automatic results();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1 && cmd_ack === 1'b1 && cmd_write === 1'b0) begin
            @(negedge sys_clk);
            chk("cmd_rdata", exp_q.pop_front(), cmd_rdata);
        end
    end
    initial begin
        #60000;
        n_fail++;
        results();
    end
    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(4135));
        cyc(6);
        rst = 1'b0;
        op(0, 8'h12, 16'hF902, 1);
        chk("option outputs", 16'h192, 16'(opts));
        adapter_good_raw = 1'b1;
        deg(8);
        adapter_good_raw = 1'b1;
        cyc(18);
        chk("adapter_good long", 16'h0, 16'(adapter_good));
        cyc(4);
        chk("adapter_switch", 16'h1, 16'(adapter_switch));
        op(1, 8'h15, 16'h1000, 1);
        op(1, 8'h12, 16'hF942, 1);
        cyc(2);
        chk("adapter_switch", 16'h0, 16'(adapter_switch));
        battery_below_fall = 1'b1;
        cyc(4);
        chk("calibration end", 16'h5, 16'({calibration_active, adapter_switch,
            battery_switch, battery_depleted}));
        battery_below_fall = 1'b0;
        cyc(2);
        chk("battery_depleted", 16'h1, 16'(battery_depleted));
        battery_above_rise = 1'b1;
        cyc(2);
        chk("battery_depleted", 16'h0, 16'(battery_depleted));
        battery_above_rise = 1'b0;
        adapter_good_raw = 1'b0;
        cyc(2);
        deg(20);
        op(1, 8'h12, 16'h7902, 1);
        deg(8);
        op(1, 8'h15, 16'h0000, 1);
        op(1, 8'h12, 16'h7942, 1);
        battery_below_fall = 1'b1;
        cyc(4);
        chk("depletion off", 16'h2, 16'({calibration_active, battery_depleted}));
        battery_below_fall = 1'b0;
        for (int i = 0; i < 4; i++) begin
            w = 16'($urandom) & 16'hFFB3;
            adapter_detect_above_2v4 = 1'($urandom);
            e = (w & 16'hFFEF) | {11'h0, adapter_detect_above_2v4, 4'h0};
            op(1, 8'h12, w, 1);
            chk("option outputs", 16'({w[12:7], w[5], w[1:0]}), 16'(opts));
            op(0, 8'h12, e, 1);
        end
        supply_above_uvlo = 1'b0;
        op(1, 8'h12, 16'h0000, 0);
        supply_above_uvlo = 1'b1;
        adapter_detect_above_0v6 = 1'b0;
        op(0, 8'h12, 16'h0000, 0);
        adapter_detect_above_0v6 = 1'b1;
        op(1, 8'h13, 16'h0000, 0);
        op(0, 8'h14, 16'h0000, 0);
        op(0, 8'h12, e, 1);
        for (int k = 0; k < 3; k++) begin
            op(1, 8'h12, {1'b0, 2'(k + 1), 13'h0102}, 1);
            op(1, 8'h15, 16'h1000, 1);
            cyc(lim[k] - 10);
            op(1, 8'h14, 16'h0400, 1);
            cyc(lim[k] - 5);
            chk("charge_suspended", 16'h0, 16'(charge_suspended));
            cyc(10);
            chk("charge_suspended", 16'h1, 16'(charge_suspended));
            op(1, 8'h15, 16'h1000, 1);
            chk("charge_suspended", 16'h0, 16'(charge_suspended));
        end
        op(1, 8'h12, 16'h0102, 1);
        cyc(120);
        chk("charge_suspended", 16'h0, 16'(charge_suspended));
        results();
    end
endmodule // charger_option_control_bench
bind charger_option_control charger_option_properties i_chk (.*);
